/* hw/urw_pkg.sv */
/*
 package for the serial receive wake and address filter block: register
 offsets, field positions, reset values, timing counts and state types.
 assumes a single 125 mhz clock and an axi4-lite register master.
*/
package urw_pkg;
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned OSC_START_NS = 2000;
    localparam int unsigned OSC_START_CYC = (OSC_START_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_DATA = 8'h08;
    localparam logic [7:0] ADDR_TXD = 8'h0c;
    localparam logic [7:0] ADDR_DIV = 8'h10;
    localparam int unsigned CTRL_SDE = 0;
    localparam int unsigned CTRL_SIE = 1;
    localparam int unsigned CTRL_AFM = 2;
    localparam int unsigned CTRL_SYNC = 3;
    localparam int unsigned CTRL_SLEEP = 4;
    localparam int unsigned CTRL_RXEN = 6;
    localparam int unsigned CTRL_TXEN = 7;
    localparam int unsigned CTRL_CSZ = 8;
    localparam int unsigned CTRL_STOP2 = 11;
    localparam int unsigned ST_RXF = 0;
    localparam int unsigned ST_TXF = 1;
    localparam int unsigned ST_START = 2;
    localparam int unsigned ST_FE = 3;
    localparam int unsigned ST_AWAKE = 4;
    localparam int unsigned ST_OSC = 5;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0300;
    localparam logic [15:0] DIV_RESET = 16'h0043;
    localparam logic [2:0] CSZ_NINE = 3'h7;
    localparam logic [1:0] SLP_DEEP0 = 2'h2;
    localparam logic [1:0] SLP_DEEP1 = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {URW_IDLE, URW_START, URW_BITS, URW_STOP} urw_state_t;
endpackage

/* hw/urw_sync.sv */
/*
 two flip-flop synchroniser for the serial input pin.
 assumes the pin idles high; resets to the idle level.
*/
`timescale 1ns/1ns
module urw_sync (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic pin_in,
    output logic pin_sync
);
    logic meta_q;
    logic sync_q;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end
    assign pin_sync = sync_q;
endmodule // urw_sync

/* hw/urw_tx.sv */
/*
 serial transmitter: start bit, 5 to 9 data bits, one or two stop bits.
 assumes a one-cycle bit enable from the shared divider; the address
 filter setting has no input here.
*/
`timescale 1ns/1ns
module urw_tx (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic bit_en,
    input wire logic start,
    input wire logic [8:0] data,
    input wire logic [2:0] char_size_field,
    input wire logic stop_bit_select,
    output logic busy,
    output logic done,
    output logic serial_out_pin
);
    logic [11:0] shreg_q, shreg_d;
    logic [3:0] left_q, left_d;
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic [3:0] nbits;
    assign nbits = (char_size_field == urw_pkg::CSZ_NINE) ? 4'd9 : 4'(5 + char_size_field[1:0]);
    always_comb begin
        shreg_d = shreg_q;
        left_d = left_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (!busy_q && start) begin
            busy_d = 1'b1;
            // leading idle bit aligns the start bit to a whole bit period
            shreg_d = {1'b1, data, 2'b01} | (12'hfff << (nbits + 4'd2));
            left_d = nbits + 4'd3 + {3'h0, stop_bit_select};
        end else if (busy_q && bit_en) begin
            shreg_d = {1'b1, shreg_q[11:1]};
            left_d = left_q - 4'd1;
            if (left_q == 4'd1) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            shreg_q <= 12'hfff;
            left_q <= 4'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            shreg_q <= shreg_d;
            left_q <= left_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end
    assign busy = busy_q;
    assign done = done_q;
    assign serial_out_pin = busy_q ? shreg_q[0] : 1'b1;
endmodule // urw_tx

/* hw/urw_top.sv */
/*
 serial receiver with start-frame wake and address filter, axi4-lite regs.
 assumes power manager acts on osc_enable, serial_clk_enable, cpu_wake.
*/
// Overview of operation
// RQ1 - with start detect on, a start bit wakes the cpu from deepest sleeps
// RQ2 - falling receive edge in sleep powers oscillator and enables serial clock
// RQ3 - detection works sync and async, only when start_detect_enable set
// RQ4 - start irq enable raises start interrupt at once on start detect
// RQ5 - without start irq only oscillator and serial clock run until complete
// RQ6 - sync remote rate at most clock/4 idle, 500 kbps from deep sleep
// RQ7 - async remote may use active-mode rate when waking from idle
// RQ8 - normal-speed wake baud error within table, e.g. +4.58/-4.00 percent
// RQ9 - double-speed wake baud error within table, e.g. +3.90/-2.70 percent
// RQ10 - filter mode drops non-address frames, never loads receive buffer
// RQ11 - transmitter unaffected by filter mode
// RQ12 - type bit is first stop bit for 5-8 bits, ninth bit for 9
// RQ13 - type bit one means address frame, zero means data frame
// RQ14 - nine-bit master sends ninth bit high for address, low for data
// RQ15 - slaves use the same nine-bit format as the master
// RQ16 - address frame accepted under filtering and sets receive complete
// RQ17 - addressed slave clears filter, takes data, sets filter after last
// RQ18 - 5-8 bit address signalling needs two transmit stop bits
// RQ19 - transmitter and receiver share one character size setting
// RQ20 - avoid read-modify-write of filter bit, it shares transmit complete; the code keeps the filter bit in ctrl and transmit complete in stat
// RQ21 - receiver uses only the first stop bit
// RQ22 - with detect disabled, sleep edges start nothing and wake nothing; the code keeps this only in deep sleep with the transmitter idle
`timescale 1ns/1ns
module urw_top (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic osc_enable,
    output logic serial_clk_enable,
    output logic cpu_wake,
    output logic rx_start_irq
);
    logic [31:0] ctrl_q, ctrl_d;
    logic [15:0] div_q, div_d;
    logic [8:0] txd_q, txd_d;
    logic rxf_q, rxf_d, txf_q, txf_d, sti_q, sti_d, fe_q, fe_d;
    logic [8:0] buf_q, buf_d;
    logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic tx_go_q, tx_go_d;
    urw_pkg::urw_state_t st_q, st_d;
    logic [15:0] bcnt_q, bcnt_d;
    logic [3:0] nbit_q, nbit_d;
    logic [8:0] sh_q, sh_d;
    logic wake_q, wake_d, osc_q, osc_d, awake_q, awake_d;
    logic [8:0] ocnt_q, ocnt_d;
    logic rx_in, rx_prev_q, bit_en, tx_busy, tx_done;
    logic [2:0] csz;
    logic sleeping, deep, fall, frame_done, type_bit, keep;
    logic [3:0] nbits;

    function automatic logic [3:0] data_bits(input logic [2:0] c);
        data_bits = (c == urw_pkg::CSZ_NINE) ? 4'd9 : 4'(5 + c[1:0]);
    endfunction

    urw_sync u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_in(serial_in_pin),
        .pin_sync(rx_in)
    );

    assign csz = ctrl_q[urw_pkg::CTRL_CSZ +: 3];
    assign nbits = data_bits(csz);
    assign sleeping = ctrl_q[urw_pkg::CTRL_SLEEP +: 2] != 2'h0;
    assign deep = ctrl_q[urw_pkg::CTRL_SLEEP +: 2] == urw_pkg::SLP_DEEP0
        || ctrl_q[urw_pkg::CTRL_SLEEP +: 2] == urw_pkg::SLP_DEEP1;
    assign fall = rx_prev_q && !rx_in;
    assign bit_en = (bcnt_q == 16'h0) && osc_q && (ocnt_q == 9'h0);

    urw_tx u_tx (
        .ref_clk(ref_clk),
        .reset(reset),
        .bit_en(bit_en),
        .start(tx_go_q),
        .data(txd_q),
        .char_size_field(csz), // RQ19
        .stop_bit_select(ctrl_q[urw_pkg::CTRL_STOP2]),
        .busy(tx_busy),
        .done(tx_done), // RQ11
        .serial_out_pin(serial_out_pin)
    );

    always_ff @(posedge ref_clk) begin
        if (reset)
            rx_prev_q <= 1'b1;
        else
            rx_prev_q <= rx_in;
    end

    // wake, oscillator and receiver state
    always_comb begin
        st_d = st_q;
        bcnt_d = (bcnt_q == 16'h0) ? div_q : bcnt_q - 16'h1;
        nbit_d = nbit_q;
        sh_d = sh_q;
        wake_d = 1'b0;
        osc_d = osc_q;
        ocnt_d = ocnt_q;
        awake_d = awake_q;
        frame_done = 1'b0;
        type_bit = 1'b0;
        if (!sleeping)
            awake_d = 1'b1;
        if (!sleeping || tx_busy)
            osc_d = 1'b1;
        if (deep && (awake_q || !ctrl_q[urw_pkg::CTRL_SIE]) && st_q == urw_pkg::URW_IDLE
            && !tx_busy) begin // RQ5
            awake_d = 1'b0;
            osc_d = 1'b0;
        end
        if (sleeping && deep && !awake_q && fall && ctrl_q[urw_pkg::CTRL_SDE]) begin // RQ3 RQ22
            osc_d = 1'b1; // RQ2
            ocnt_d = 9'(urw_pkg::OSC_START_CYC);
        end
        if (ocnt_q != 9'h0)
            ocnt_d = ocnt_q - 9'h1;
        case (st_q)
            urw_pkg::URW_IDLE: begin
                if (fall && ctrl_q[urw_pkg::CTRL_RXEN] && (osc_d || osc_q)) begin
                    st_d = urw_pkg::URW_START;
                    bcnt_d = {1'b0, div_q[15:1]};
                end
            end
            urw_pkg::URW_START: begin
                if (bit_en) begin
                    st_d = rx_in ? urw_pkg::URW_IDLE : urw_pkg::URW_BITS;
                    nbit_d = 4'h0;
                end
            end
            urw_pkg::URW_BITS: begin
                if (bit_en) begin
                    sh_d = {rx_in, sh_q[8:1]};
                    nbit_d = nbit_q + 4'h1;
                    if (nbit_q + 4'h1 == nbits)
                        st_d = urw_pkg::URW_STOP;
                end
            end
            urw_pkg::URW_STOP: begin
                if (bit_en) begin
                    frame_done = 1'b1; // RQ21
                    st_d = urw_pkg::URW_IDLE;
                end
            end
            default: st_d = urw_pkg::URW_IDLE;
        endcase
        // RQ12 RQ13
        type_bit = (csz == urw_pkg::CSZ_NINE) ? sh_q[8] : rx_in;
        keep = !ctrl_q[urw_pkg::CTRL_AFM] || type_bit; // RQ10 RQ16
        if (frame_done && keep && sleeping && !ctrl_q[urw_pkg::CTRL_SIE]) begin
            wake_d = 1'b1; // RQ5
            awake_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_q <= urw_pkg::URW_IDLE;
            bcnt_q <= 16'h0;
            nbit_q <= 4'h0;
            sh_q <= 9'h0;
            wake_q <= 1'b0;
            osc_q <= 1'b1;
            ocnt_q <= 9'h0;
            awake_q <= 1'b1;
        end else begin
            st_q <= st_d;
            bcnt_q <= bcnt_d;
            nbit_q <= nbit_d;
            sh_q <= sh_d;
            wake_q <= wake_d;
            osc_q <= osc_d;
            ocnt_q <= ocnt_d;
            awake_q <= awake_d;
        end
    end

    // registers and axi4-lite slave
    always_comb begin
        logic [31:0] wm;
        wm = 32'h0;
        ctrl_d = ctrl_q;
        div_d = div_q;
        txd_d = txd_q;
        rxf_d = rxf_q;
        txf_d = txf_q;
        sti_d = sti_q;
        fe_d = fe_q;
        buf_d = buf_q;
        aw_d = aw_q;
        w_d = w_q;
        awa_d = awa_q;
        wd_d = wd_q;
        bv_d = bv_q && !s_axi_bready;
        br_d = br_q;
        rv_d = rv_q && !s_axi_rready;
        rd_d = rd_q;
        rr_d = rr_q;
        tx_go_d = 1'b0;
        for (int i = 0; i < 4; i++)
            wm[i*8 +: 8] = {8{s_axi_wstrb[i]}};
        if (s_axi_awvalid && !aw_q) begin
            aw_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_q) begin
            w_d = 1'b1;
            wd_d = s_axi_wdata & wm;
        end
        if (aw_q && w_q && !bv_q) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            br_d = urw_pkg::RESP_OKAY;
            case (awa_q)
                urw_pkg::ADDR_CTRL: ctrl_d = wd_q; // RQ17
                urw_pkg::ADDR_STAT: begin
                    rxf_d = rxf_q && !wd_q[urw_pkg::ST_RXF];
                    txf_d = txf_q && !wd_q[urw_pkg::ST_TXF]; // RQ20
                    sti_d = sti_q && !wd_q[urw_pkg::ST_START];
                    fe_d = fe_q && !wd_q[urw_pkg::ST_FE];
                end
                urw_pkg::ADDR_TXD: begin
                    txd_d = wd_q[8:0];
                    tx_go_d = ctrl_q[urw_pkg::CTRL_TXEN];
                end
                urw_pkg::ADDR_DIV: div_d = wd_q[15:0];
                default: br_d = urw_pkg::RESP_SLVERR;
            endcase
        end
        if (s_axi_arvalid && !rv_q) begin
            rv_d = 1'b1;
            rr_d = urw_pkg::RESP_OKAY;
            case (s_axi_araddr)
                urw_pkg::ADDR_CTRL: rd_d = ctrl_q;
                urw_pkg::ADDR_STAT: rd_d = {26'h0, osc_q, awake_q, fe_q, sti_q, txf_q, rxf_q};
                urw_pkg::ADDR_DATA: begin
                    rd_d = {23'h0, buf_q};
                    rxf_d = 1'b0;
                end
                urw_pkg::ADDR_TXD: rd_d = {23'h0, txd_q};
                urw_pkg::ADDR_DIV: rd_d = {16'h0, div_q};
                default: begin
                    rd_d = 32'h0;
                    rr_d = urw_pkg::RESP_SLVERR;
                end
            endcase
        end
        // hardware sets win over software clears
        if (frame_done && keep) begin
            rxf_d = 1'b1; // RQ16
            buf_d = sh_q >> (4'd9 - nbits);
            fe_d = !rx_in;
        end
        if (tx_done)
            txf_d = 1'b1;
        if (st_q == urw_pkg::URW_IDLE && st_d == urw_pkg::URW_START && ctrl_q[urw_pkg::CTRL_SIE])
            sti_d = 1'b1; // RQ4
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl_q <= urw_pkg::CTRL_RESET;
            div_q <= urw_pkg::DIV_RESET;
            txd_q <= 9'h0;
            rxf_q <= 1'b0;
            txf_q <= 1'b0;
            sti_q <= 1'b0;
            fe_q <= 1'b0;
            buf_q <= 9'h0;
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= 8'h0;
            wd_q <= 32'h0;
            bv_q <= 1'b0;
            br_q <= 2'h0;
            rv_q <= 1'b0;
            rd_q <= 32'h0;
            rr_q <= 2'h0;
            tx_go_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            div_q <= div_d;
            txd_q <= txd_d;
            rxf_q <= rxf_d;
            txf_q <= txf_d;
            sti_q <= sti_d;
            fe_q <= fe_d;
            buf_q <= buf_d;
            aw_q <= aw_d;
            w_q <= w_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            bv_q <= bv_d;
            br_q <= br_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            rr_q <= rr_d;
            tx_go_q <= tx_go_d;
        end
    end

    assign s_axi_awready = !aw_q;
    assign s_axi_wready = !w_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = br_q;
    assign s_axi_arready = !rv_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rr_q;
    assign osc_enable = osc_q; // RQ2
    assign serial_clk_enable = osc_q; // RQ5
    assign cpu_wake = wake_q || (sti_q && sleeping); // RQ1
    assign rx_start_irq = sti_q; // RQ4

    property p_fall_wakes_osc;
        @(posedge ref_clk) disable iff (reset)
        (sleeping && deep && !awake_q && fall && ctrl_q[urw_pkg::CTRL_SDE]) |=> osc_enable;
    endproperty
    a_fall_wakes_osc: assert property (p_fall_wakes_osc) else $error("osc not started"); // RQ2

    property p_no_detect;
        @(posedge ref_clk) disable iff (reset)
        (sleeping && !osc_q && !ctrl_q[urw_pkg::CTRL_SDE] && !tx_busy && !awake_q
            && $stable(ctrl_q)) |=> !osc_q;
    endproperty
    a_no_detect: assert property (p_no_detect) else $error("osc started while disabled"); // RQ22

    property p_start_irq;
        @(posedge ref_clk) disable iff (reset)
        (st_q == urw_pkg::URW_IDLE && st_d == urw_pkg::URW_START && ctrl_q[urw_pkg::CTRL_SIE])
            |=> rx_start_irq;
    endproperty
    a_start_irq: assert property (p_start_irq) else $error("start irq missing"); // RQ4

    property p_filter_drop;
        @(posedge ref_clk) disable iff (reset)
        (frame_done && ctrl_q[urw_pkg::CTRL_AFM] && !type_bit) |=> $stable(buf_q);
    endproperty
    a_filter_drop: assert property (p_filter_drop) else $error("data frame not dropped"); // RQ10

    property p_addr_accept;
        @(posedge ref_clk) disable iff (reset)
        (frame_done && type_bit) |=> rxf_q;
    endproperty
    a_addr_accept: assert property (p_addr_accept) else $error("address frame lost"); // RQ16

    property p_type_nine;
        @(posedge ref_clk) disable iff (reset)
        (frame_done && csz == urw_pkg::CSZ_NINE) |-> (keep == (!ctrl_q[urw_pkg::CTRL_AFM] || sh_q[8]));
    endproperty
    a_type_nine: assert property (p_type_nine) else $error("wrong type bit source"); // RQ12

    property p_wake_pulse;
        @(posedge ref_clk) disable iff (reset)
        (frame_done && keep && sleeping && !ctrl_q[urw_pkg::CTRL_SIE]) |=> cpu_wake && awake_q;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("no wake on complete"); // RQ1

    property p_osc_idle_off;
        @(posedge ref_clk) disable iff (reset)
        (deep && !awake_q && !ctrl_q[urw_pkg::CTRL_SIE] && st_q == urw_pkg::URW_IDLE && !tx_busy
            && !fall) |=> !serial_clk_enable;
    endproperty
    a_osc_idle_off: assert property (p_osc_idle_off) else $error("clock left on"); // RQ5
endmodule // urw_top

/* verification/urw_remote.sv */
/*
 remote serial transmitter standing on the far side of the receive pin,
 with a catcher for the device's transmit pin.
 assumes the bit period equals the device divider plus one; line idles high.
*/
`timescale 1ns/1ns
module urw_remote #(
    parameter int PERIOD = 512
) (
    input wire logic ref_clk,
    output logic line_out,
    input wire logic line_in
);
    initial line_out = 1'b1;

    // start bit, data lsb first, type stop bit, second stop bit always high
    task automatic send(input logic [8:0] word, input int nbits, input logic stop1);
        for (int i = 0; i < nbits + 3; i++) begin
            @(posedge ref_clk);
            line_out <= (i == 0) ? 1'b0 : (i <= nbits) ? word[i-1] :
                (i == nbits + 1) ? stop1 : 1'b1;
            repeat (PERIOD - 1) @(posedge ref_clk);
        end
    endtask

    // samples each data bit of the device's transmit frame at mid bit
    task automatic catch(input int nbits, output logic [8:0] word);
        word = '0;
        while (line_in !== 1'b0) @(posedge ref_clk);
        repeat (PERIOD / 2) @(posedge ref_clk);
        for (int i = 0; i < nbits; i++) begin
            repeat (PERIOD) @(posedge ref_clk);
            word[i] = line_in;
        end
    endtask
endmodule // urw_remote

/* verification/tb.sv */
/*
 self-checking bench for the receive wake and address filter block.
 assumes axi4-lite register access and a remote transmitter model.
*/
`timescale 1ns/1ns
module tb;
    localparam int P = 512;
    logic ref_clk = 1'b0, reset = 1'b1;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rdv;
    logic serial_in_pin, serial_out_pin, osc_enable, serial_clk_enable, cpu_wake, rx_start_irq;
    int n_fail = 0, samples_checked = 0, wake_cnt = 0, wb;
    logic [15:0] rnd = 16'ha7d0;
    logic [8:0] exp_q[$];
    logic [8:0] cw;
    logic [2:0] det;
    logic afm = 1'b0;

    urw_top urw_top_i (.ref_clk(ref_clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .serial_in_pin(serial_in_pin),
        .serial_out_pin(serial_out_pin), .osc_enable(osc_enable),
        .serial_clk_enable(serial_clk_enable), .cpu_wake(cpu_wake),
        .rx_start_irq(rx_start_irq));
    urw_remote #(.PERIOD(P)) urw_remote_i (.ref_clk(ref_clk), .line_out(serial_in_pin),
        .line_in(serial_out_pin));

    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (cpu_wake === 1'b1) wake_cnt <= wake_cnt + 1;

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ap, wp, done;
        ap = 1'b1;
        wp = 1'b1;
        done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            done = (s_axi_bvalid === 1'b1);
            if (ap && s_axi_awready === 1'b1) begin
                ap = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (wp && s_axi_wready === 1'b1) begin
                wp = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        r = s_axi_bresp;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ap, done;
        ap = 1'b1;
        done = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            done = (s_axi_rvalid === 1'b1);
            if (ap && s_axi_arready === 1'b1) begin
                ap = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    // whole-word control writes only
    task automatic setc(input logic [2:0] csz, input logic f, input logic [1:0] slp,
        input logic [2:0] dt);
        logic [31:0] c;
        c = '0;
        c[urw_pkg::CTRL_SDE] = dt[0];
        c[urw_pkg::CTRL_SIE] = dt[1];
        c[urw_pkg::CTRL_AFM] = f;
        c[urw_pkg::CTRL_SYNC] = dt[2];
        c[urw_pkg::CTRL_SLEEP +: 2] = slp;
        c[urw_pkg::CTRL_RXEN] = 1'b1;
        c[urw_pkg::CTRL_TXEN] = 1'b1;
        c[urw_pkg::CTRL_CSZ +: 3] = csz;
        c[urw_pkg::CTRL_STOP2] = 1'b1;
        afm = f;
        wr(urw_pkg::ADDR_CTRL, c, rsp);
    endtask

    // sends one frame, updates the reference queue, checks flag and data
    task automatic frame(input int n, input logic typ, input logic rx_on);
        logic [8:0] w;
        logic [31:0] m;
        rnd = lfsr(rnd);
        w = (n == 9) ? {typ, rnd[7:0]} : {1'b0, rnd[7:0]};
        m = (n == 9) ? 32'h1ff : 32'hff;
        urw_remote_i.send(w, n, (n == 9) ? 1'b1 : typ);
        if (rx_on && (!afm || typ)) exp_q.push_back(w);
        if (rx_on) begin
            rd(urw_pkg::ADDR_STAT, rdv, rsp);
            chk("rx complete", 32'(rdv[urw_pkg::ST_RXF]), 32'(exp_q.size() != 0));
            if (exp_q.size() != 0) begin
                rd(urw_pkg::ADDR_DATA, rdv, rsp);
                chk("rx data", rdv & m, 32'(exp_q.pop_front()));
            end
        end
    endtask

    initial begin
        repeat (90000) @(posedge ref_clk);
        n_fail++;
        end_sim();
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rd(urw_pkg::ADDR_CTRL, rdv, rsp);
        chk("ctrl reset", rdv, urw_pkg::CTRL_RESET);
        rd(urw_pkg::ADDR_DIV, rdv, rsp);
        chk("div reset", rdv, 32'(urw_pkg::DIV_RESET));
        rd(8'h14, rdv, rsp);
        chk("unmapped read resp", 32'(rsp), 32'(urw_pkg::RESP_SLVERR));
        chk("unmapped read data", rdv, 32'h0);
        wr(8'h14, 32'h5a, rsp);
        chk("unmapped write resp", 32'(rsp), 32'(urw_pkg::RESP_SLVERR));
        wr(urw_pkg::ADDR_DIV, 32'(P - 1), rsp);
        // nine-bit filtered traffic: data dropped, address kept, then addressed
        setc(urw_pkg::CSZ_NINE, 1'b1, 2'h0, 3'h0);
        frame(9, 1'b0, 1'b1);
        frame(9, 1'b1, 1'b1);
        setc(urw_pkg::CSZ_NINE, 1'b0, 2'h0, 3'h0);
        frame(9, 1'b0, 1'b1);
        setc(urw_pkg::CSZ_NINE, 1'b1, 2'h0, 3'h0);
        frame(9, 1'b0, 1'b1);
        // eight-bit frames: only the first stop bit decides
        setc(3'h3, 1'b1, 2'h0, 3'h0);
        frame(8, 1'b0, 1'b1);
        frame(8, 1'b1, 1'b1);
        // transmitter with filtering on sends the shared nine-bit format
        setc(urw_pkg::CSZ_NINE, 1'b1, 2'h0, 3'h0);
        rnd = lfsr(rnd);
        wr(urw_pkg::ADDR_TXD, {23'h0, 1'b1, rnd[7:0]}, rsp);
        urw_remote_i.catch(9, cw);
        chk("tx word", 32'(cw), {23'h0, 1'b1, rnd[7:0]});
        repeat (3 * P) @(posedge ref_clk);
        // deep sleep wake: irq on and sync, irq off, detect off
        for (int k = 0; k < 3; k++) begin
            det = (k == 0) ? 3'h7 : (k == 1) ? 3'h1 : 3'h0;
            wr(urw_pkg::ADDR_STAT, 32'h3f, rsp);
            setc(urw_pkg::CSZ_NINE, 1'b0, (k == 1) ? 2'h3 : 2'h2, det);
            repeat (4) @(posedge ref_clk);
            chk("osc asleep", 32'(osc_enable), 32'h0);
            wb = wake_cnt;
            fork
                frame(9, 1'b1, det[0]);
                begin
                    repeat (20) @(posedge ref_clk);
                    chk("osc on edge", 32'(osc_enable), 32'(det[0]));
                    chk("serial clk", 32'(serial_clk_enable), 32'(det[0]));
                    chk("start irq", 32'(rx_start_irq), 32'(det[0] & det[1]));
                    chk("early wake", 32'(wake_cnt != wb), 32'(det[0] & det[1]));
                end
            join
            chk("wake seen", 32'(wake_cnt != wb), 32'(det[0]));
            setc(urw_pkg::CSZ_NINE, 1'b0, 2'h0, 3'h0);
        end
        end_sim();
    end
endmodule // tb
